/* File: rpcs_pkg.sv */
// Purpose: shared constants for the record power and clock sequencing host
// Assumes: 50 MHz pclk, device control port reached by a 3-wire serial writer
// Notes:   device register addresses and bit positions are listed once here
package rpcs_pkg;

  // clock
  localparam int CLK_NS            = 20;

  // timing, figures in their own unit, counts derived
  localparam int RST_LOW_NS        = 150;
  localparam int RST_LOW_CYC       = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int VCM_TO_PLL_NS     = 2000000;
  localparam int VCM_TO_PLL_CYC    = VCM_TO_PLL_NS / CLK_NS;
  localparam int PLL_TO_ADC_NS     = 6000000;
  localparam int PLL_TO_ADC_CYC    = PLL_TO_ADC_NS / CLK_NS;
  localparam int PLL_LOCK_NS       = 40000000;
  localparam int PLL_LOCK_CYC      = PLL_LOCK_NS / CLK_NS;
  localparam int CNT_W             = 22;

  // device control addresses
  localparam logic [6:0] DEV_PWR   = 7'h00;
  localparam logic [6:0] DEV_CLK   = 7'h01;
  localparam logic [6:0] DEV_MIC_A = 7'h02;
  localparam logic [6:0] DEV_MIC_B = 7'h03;
  localparam logic [6:0] DEV_FS    = 7'h05;
  localparam logic [6:0] DEV_TMR   = 7'h0A;
  localparam logic [6:0] DEV_REF   = 7'h0B;
  localparam logic [6:0] DEV_LIM   = 7'h0C;

  // device bit positions
  localparam int PWR_ADC_LEFT      = 0;
  localparam int PWR_ADC_RIGHT     = 1;
  localparam int PWR_VCM           = 2;
  localparam int PWR_MIC_AMP       = 3;
  localparam int CLK_PLL           = 0;
  localparam int CLK_MASTER        = 1;
  localparam int CLK_MCLK_OUT      = 2;
  localparam int LIM_ALC_EN        = 7;
  localparam logic [7:0] DEV_RST   = 8'h00;

  // serial frame
  localparam int SER_BITS          = 16;

  // apb register offsets and fields
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_MODE  = 8'h04;
  localparam logic [7:0] REG_FS    = 8'h08;
  localparam logic [7:0] REG_MIC   = 8'h0C;
  localparam logic [7:0] REG_ALC   = 8'h10;
  localparam logic [7:0] REG_STAT  = 8'h14;
  localparam int CMD_START         = 0;
  localparam int CMD_STOP          = 1;
  localparam int CMD_CLK_STOP      = 2;
  localparam int CMD_PWR_OFF       = 3;
  localparam int CMD_RESET         = 4;
  localparam logic [2:0] MODE_RST  = 3'h0;

  typedef enum logic [2:0] {
    MD_PLL_MASTER = 3'b000,
    MD_PLL_FRAME  = 3'b001,
    MD_PLL_MCK    = 3'b010,
    MD_EXT_SLAVE  = 3'b011,
    MD_EXT_MASTER = 3'b100
  } rpcs_mode_e;

endpackage

/* File: rpcs_ctrl_wr.sv */
// Purpose: 3-wire serial writer for the device control port
// Assumes: one 16-bit frame per write, write flag first, msb first
// Notes:   serial clock is pclk divided by four
`timescale 1ns/1ns
module rpcs_ctrl_wr
  import rpcs_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // write request
  input  wire logic        wr_valid,
  input  wire logic [6:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  output logic             wr_ready,
  // serial pins
  output logic             ctrl_csn,
  output logic             ctrl_cclk,
  output logic             ctrl_cdata
);

  typedef struct packed {
    logic        busy;
    logic [1:0]  div;
    logic [4:0]  bits;
    logic [15:0] shreg;
    logic        csn;
    logic        cclk;
    logic        cdo;
    logic        ready;
  } rpcs_wr_s;

  rpcs_wr_s s_q;
  rpcs_wr_s s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.busy) begin
      if (wr_valid && s_q.ready) begin
        s_d.busy  = 1'b1;
        s_d.shreg = {1'b1, wr_addr, wr_data};
        s_d.div   = 2'h0;
        s_d.bits  = 5'h00;
        s_d.csn   = 1'b0;
      end
    end else begin
      s_d.div = s_q.div + 2'h1;
      case (s_q.div)
        2'h0: begin
          s_d.cclk = 1'b0;
          s_d.cdo  = s_q.shreg[15];
        end
        2'h2: s_d.cclk = 1'b1;
        2'h3: begin
          s_d.shreg = {s_q.shreg[14:0], 1'b0};
          s_d.bits  = s_q.bits + 5'h01;
          if (s_q.bits == 5'(SER_BITS - 1)) begin
            s_d.busy = 1'b0;
            s_d.csn  = 1'b1;
          end
        end
        default: s_d.div = s_q.div + 2'h1;
      endcase
    end
    // ready drops the cycle after acceptance so the caller can see completion
    s_d.ready = !s_d.busy;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{busy: 1'b0, div: 2'h0, bits: 5'h00, shreg: 16'h0000,
               csn: 1'b1, cclk: 1'b1, cdo: 1'b0, ready: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign wr_ready   = s_q.ready;
  assign ctrl_csn   = s_q.csn;
  assign ctrl_cclk  = s_q.cclk;
  assign ctrl_cdata = s_q.cdo;

  chk_frame_length: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(s_q.csn) |-> !s_q.csn [*8] ##0 (!s_q.csn)[*8]) else $error("serial frame ended early");

endmodule

/* File: rpcs_host.sv */
// Purpose: host sequencer powering, recording and clock stopping of the audio front end
// Assumes: apb slave at 50 MHz, device reached by its serial control port and pins
// Notes:   clock sources outside are gated by the *_run outputs
`timescale 1ns/1ns
module rpcs_host
  import rpcs_pkg::*;
#(
  parameter int T_VCM_PLL = VCM_TO_PLL_CYC,
  parameter int T_PLL_ADC = PLL_TO_ADC_CYC,
  parameter int T_LOCK    = PLL_LOCK_CYC
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // device pins
  output logic             power_down_pin_n,
  output logic             ctrl_csn,
  output logic             ctrl_cclk,
  output logic             ctrl_cdata,
  // external clock source gates
  output logic             mck_run,
  output logic             bclk_run,
  output logic             frame_run
);

  typedef enum logic [4:0] {
    S_PINRST  = 5'b00000,
    S_IDLE    = 5'b00001,
    S_FS      = 5'b00010,
    S_LOCK    = 5'b00011,
    S_MIC_A   = 5'b00100,
    S_MIC_B   = 5'b00101,
    S_TMR     = 5'b00110,
    S_REF     = 5'b00111,
    S_LIM     = 5'b01000,
    S_PWR1    = 5'b01001,
    S_WAIT2   = 5'b01010,
    S_PLL     = 5'b01011,
    S_WAIT6   = 5'b01100,
    S_ADC     = 5'b01101,
    S_STOP    = 5'b01110,
    S_ALC_OFF = 5'b01111,
    S_CK_PLL  = 5'b10000,
    S_CK_MOUT = 5'b10001,
    S_CK_OFF  = 5'b10010,
    S_VCM_OFF = 5'b10011,
    S_WRITE   = 5'b10100,
    S_WDONE   = 5'b10101
  } rpcs_st_e;

  typedef struct packed {
    rpcs_st_e         st;
    rpcs_st_e         nxt;
    logic [CNT_W-1:0] cnt;
    rpcs_mode_e       mode;
    logic [7:0]       fs;
    logic [7:0]       mic_a;
    logic [7:0]       mic_b;
    logic [7:0]       tmr;
    logic [7:0]       ref_v;
    logic [7:0]       lim;
    logic [7:0]       pwr;
    logic [7:0]       clk;
    logic             recording;
    logic             wr_valid;
    logic [6:0]       wr_addr;
    logic [7:0]       wr_data;
    logic             rst_pin_n;
    logic             mck;
    logic             bclk;
    logic             frame;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } rpcs_s;

  rpcs_s    s_q;
  rpcs_s    s_d;
  logic     wr_ready;

  rpcs_ctrl_wr u_wr (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_valid   (s_q.wr_valid),
    .wr_addr    (s_q.wr_addr),
    .wr_data    (s_q.wr_data),
    .wr_ready   (wr_ready),
    .ctrl_csn   (ctrl_csn),
    .ctrl_cclk  (ctrl_cclk),
    .ctrl_cdata (ctrl_cdata)
  );

  function automatic logic is_pll(rpcs_mode_e m);
    return (m == MD_PLL_MASTER) || (m == MD_PLL_FRAME) || (m == MD_PLL_MCK);
  endfunction

  function automatic logic mapped(logic [7:0] a);
    return (a == REG_CMD) || (a == REG_MODE) || (a == REG_FS) ||
           (a == REG_MIC) || (a == REG_ALC) || (a == REG_STAT);
  endfunction

  // queue one device write, then continue at the given state
  function automatic rpcs_s issue(rpcs_s s, logic [6:0] a, logic [7:0] d, rpcs_st_e after);
    rpcs_s r;
    r          = s;
    r.wr_valid = 1'b1;
    r.wr_addr  = a;
    r.wr_data  = d;
    r.nxt      = after;
    r.st       = S_WRITE;
    return r;
  endfunction

  function automatic rpcs_s wait_for(rpcs_s s, int cyc, rpcs_st_e st);
    rpcs_s r;
    r     = s;
    r.cnt = CNT_W'(cyc - 1);
    r.st  = st;
    return r;
  endfunction

  logic       acc;
  logic [4:0] cmd;
  logic       clk_on;

  always_comb begin
    s_d     = s_q;
    acc     = psel && penable && pready;
    cmd     = 5'h00;
    clk_on  = s_q.mck || s_q.bclk || s_q.frame;
    // apb: one wait state, then answer for one cycle
    s_d.pready  = psel && penable && !s_q.pready;
    s_d.pslverr = psel && penable && !s_q.pready && !mapped(paddr);
    if (psel && penable && !s_q.pready) begin
      case (paddr)
        REG_MODE: s_d.prdata = {29'h0, s_q.mode};
        REG_FS:   s_d.prdata = {24'h0, s_q.fs};
        REG_MIC:  s_d.prdata = {16'h0, s_q.mic_b, s_q.mic_a};
        REG_ALC:  s_d.prdata = {8'h0, s_q.lim, s_q.ref_v, s_q.tmr};
        REG_STAT: s_d.prdata = {16'h0, s_q.pwr[3:0], s_q.clk[3:0], s_q.st, s_q.recording,
                                s_q.rst_pin_n, (s_q.st != S_IDLE)};
        default:  s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (acc && pwrite && !pslverr) begin
      case (paddr)
        REG_CMD:  cmd = pwdata[4:0];
        // level registers only taken while adc is powered down
        REG_MODE: if (!s_q.recording) s_d.mode = rpcs_mode_e'(pwdata[2:0]);
        REG_FS:   if (!s_q.recording) s_d.fs = pwdata[7:0];
        REG_MIC:  if (!s_q.recording) {s_d.mic_b, s_d.mic_a} = pwdata[15:0];
        REG_ALC:  if (!s_q.recording) {s_d.lim, s_d.ref_v, s_d.tmr} = {1'b0, pwdata[22:0]};
        default:  cmd = 5'h00;
      endcase
    end

    case (s_q.st)
      S_PINRST: begin
        s_d.rst_pin_n = 1'b0;
        if (s_q.cnt == '0) begin
          s_d.rst_pin_n = 1'b1;
          s_d.st    = S_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      S_IDLE: begin
        if (cmd[CMD_RESET]) begin
          // device registers return to defaults, mirror them
          s_d       = wait_for(s_d, RST_LOW_CYC, S_PINRST);
          s_d.rst_pin_n = 1'b0;
          // a reset device is no longer recording
          s_d.recording = 1'b0;
          s_d.pwr   = DEV_RST;
          s_d.clk   = DEV_RST;
        end else if (cmd[CMD_START] && !s_q.recording) begin
          // clocks must run before any analog block comes up
          s_d.mck   = (s_q.mode != MD_PLL_FRAME);
          s_d.bclk  = (s_q.mode == MD_PLL_FRAME) || (s_q.mode == MD_PLL_MCK) ||
                      (s_q.mode == MD_EXT_SLAVE);
          s_d.frame = s_d.bclk;
          s_d       = issue(s_d, DEV_FS, s_q.fs, is_pll(s_q.mode) ? S_LOCK : S_MIC_A);
          if (is_pll(s_q.mode)) s_d.cnt = CNT_W'(T_LOCK - 1);
        end else if (cmd[CMD_STOP] && s_q.recording) begin
          s_d.st = S_STOP;
        end else if (cmd[CMD_CLK_STOP] && !s_q.recording && clk_on) begin
          // stop order depends on clock mode
          case (s_q.mode)
            MD_PLL_MASTER, MD_PLL_FRAME, MD_PLL_MCK: s_d.st = S_CK_PLL;
            default: s_d.st = S_CK_OFF;
          endcase
        end else if (cmd[CMD_PWR_OFF] && !s_q.recording && !clk_on && s_q.pwr[PWR_VCM]) begin
          s_d.st = S_VCM_OFF;
        end
      end
      S_LOCK: begin
        // a fresh rate needs the pll relocked before the path powers up
        if (s_q.cnt == '0) s_d.st = S_MIC_A;
        else s_d.cnt = s_q.cnt - 1'b1;
      end
      S_MIC_A: s_d = issue(s_d, DEV_MIC_A, s_q.mic_a, S_MIC_B);
      S_MIC_B: s_d = issue(s_d, DEV_MIC_B, s_q.mic_b, S_TMR);
      S_TMR:   s_d = issue(s_d, DEV_TMR, s_q.tmr, S_REF);
      S_REF:   s_d = issue(s_d, DEV_REF, s_q.ref_v, S_LIM);
      S_LIM: begin
        s_d = issue(s_d, DEV_LIM, s_q.lim | 8'h80, S_PWR1);
      end
      S_PWR1: begin
        s_d.pwr[PWR_VCM]     = 1'b1;
        s_d.pwr[PWR_MIC_AMP] = 1'b1;
        s_d = issue(s_d, DEV_PWR, s_d.pwr, S_WAIT2);
        s_d.cnt = CNT_W'(T_VCM_PLL - 1);
      end
      S_WAIT2: begin
        if (s_q.cnt == '0) s_d.st = S_PLL;
        else s_d.cnt = s_q.cnt - 1'b1;
      end
      S_PLL: begin
        s_d.clk[CLK_PLL]    = is_pll(s_q.mode);
        s_d.clk[CLK_MASTER] = (s_q.mode == MD_PLL_MASTER) || (s_q.mode == MD_EXT_MASTER);
        s_d.clk[CLK_MCLK_OUT] = (s_q.mode == MD_PLL_MASTER) || (s_q.mode == MD_PLL_MCK);
        s_d = issue(s_d, DEV_CLK, s_d.clk, S_WAIT6);
        s_d.cnt = CNT_W'(T_PLL_ADC - 1);
      end
      S_WAIT6: begin
        if (s_q.cnt == '0) s_d.st = S_ADC;
        else s_d.cnt = s_q.cnt - 1'b1;
      end
      S_ADC: begin
        s_d.pwr[PWR_ADC_LEFT]  = 1'b1;
        s_d.pwr[PWR_ADC_RIGHT] = 1'b1;
        s_d.recording          = 1'b1;
        s_d = issue(s_d, DEV_PWR, s_d.pwr, S_IDLE);
      end
      S_STOP: begin
        s_d.pwr[PWR_ADC_LEFT]  = 1'b0;
        s_d.pwr[PWR_ADC_RIGHT] = 1'b0;
        s_d.pwr[PWR_MIC_AMP]   = 1'b0;
        s_d = issue(s_d, DEV_PWR, s_d.pwr, S_ALC_OFF);
      end
      S_ALC_OFF: begin
        s_d.recording = 1'b0;
        s_d = issue(s_d, DEV_LIM, s_q.lim, S_IDLE);
      end
      S_CK_PLL: begin
        s_d.clk[CLK_PLL]    = 1'b0;
        s_d.clk[CLK_MASTER] = 1'b0;
        s_d = issue(s_d, DEV_CLK, s_d.clk, (s_q.mode == MD_PLL_FRAME) ? S_CK_OFF : S_CK_MOUT);
      end
      S_CK_MOUT: begin
        s_d.clk[CLK_MCLK_OUT] = 1'b0;
        s_d = issue(s_d, DEV_CLK, s_d.clk, S_CK_OFF);
      end
      S_CK_OFF: begin
        s_d.mck   = 1'b0;
        s_d.bclk  = 1'b0;
        s_d.frame = 1'b0;
        s_d.st    = S_IDLE;
      end
      S_VCM_OFF: begin
        s_d.pwr = DEV_RST;
        s_d = issue(s_d, DEV_PWR, DEV_RST, S_IDLE);
      end
      S_WRITE: begin
        if (wr_ready) begin
          s_d.wr_valid = 1'b0;
          s_d.st       = S_WDONE;
        end
      end
      S_WDONE: begin
        // next step only once the frame has left the pins
        if (wr_ready) s_d.st = s_q.nxt;
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.st     <= S_PINRST;
      s_q.nxt    <= S_IDLE;
      s_q.cnt    <= CNT_W'(RST_LOW_CYC - 1);
      s_q.mode   <= rpcs_mode_e'(MODE_RST);
    end else begin
      s_q <= s_d;
    end
  end

  assign pready           = s_q.pready;
  assign prdata           = s_q.prdata;
  assign pslverr          = s_q.pslverr;
  assign power_down_pin_n = s_q.rst_pin_n;
  assign mck_run          = s_q.mck;
  assign bclk_run         = s_q.bclk;
  assign frame_run        = s_q.frame;

  sequence low_pulse;
    !power_down_pin_n [*8];
  endsequence

  sequence cfg_tail;
    (s_q.st == S_REF) ##[1:200] (s_q.st == S_LIM);
  endsequence

  chk_pin_width: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(power_down_pin_n) |-> low_pulse) else $error("power-down pulse too short");
  chk_vcm_first: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.pwr[PWR_ADC_LEFT] || s_q.pwr[PWR_MIC_AMP]) |-> s_q.pwr[PWR_VCM]) else $error("block up before vcm");
  chk_adc_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == S_ADC) |-> $past(s_q.st) == S_WAIT6 && $past(s_q.cnt) == '0) else $error("adc powered early");
  chk_cfg_order: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_tail |=> ##[1:200] (s_q.st == S_PWR1)) else $error("configuration out of order");
  chk_alc_after: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == S_ALC_OFF) |-> !s_q.pwr[PWR_ADC_LEFT] && !s_q.pwr[PWR_ADC_RIGHT]) else $error("level off first");
  chk_mck_stop: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(mck_run) |-> !s_q.clk[CLK_PLL] && !s_q.clk[CLK_MCLK_OUT] && !s_q.recording)
    else $error("mck stopped early");
  chk_frame_stop: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(frame_run) |-> !s_q.clk[CLK_PLL] && !bclk_run) else $error("frame clocks stopped with pll on");
  chk_vcm_last: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(s_q.pwr[PWR_VCM]) && s_q.rst_pin_n |-> !mck_run && s_q.pwr == DEV_RST && s_q.clk[CLK_PLL] == 1'b0)
    else $error("vcm off too soon");
  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready) else $error("apb answer not one cycle");

endmodule

/* File: rpcs_dev_model.sv */
// Purpose: behavioural model of the recording front end behind the host
// Assumes: write-only serial port, 16-bit frames, write flag first, msb first
// Notes:   logs every accepted write together with the master clock gate
`timescale 1ns/1ns
module rpcs_dev_model
  import rpcs_pkg::*;
#(
  parameter int INIT_SAMPLES = 3088
)(
  // clock
  input  wire logic pclk,
  // device pins
  input  wire logic power_down_pin_n,
  input  wire logic ctrl_csn,
  input  wire logic ctrl_cclk,
  input  wire logic ctrl_cdata,
  input  wire logic mck_run,
  // observed state
  output logic      alc_active,
  output logic      data_valid,
  output logic      dev_bclk
);
  logic [7:0]  regs [0:15];
  logic [15:0] sh;
  int          nbits;
  int          init_cnt;
  logic [7:0]  input_volume_gain;
  logic [15:0] log_q [$];

  task automatic clear_all();
    for (int i = 0; i < 16; i++) begin
      regs[i] = 8'h00;
    end
    input_volume_gain = 8'h00;
  endtask

  initial begin
    nbits = 0;
    init_cnt = 0;
    dev_bclk = 1'b0;
    clear_all();
  end

  always @(negedge power_down_pin_n) begin
    clear_all();
  end

  always @(negedge ctrl_csn) begin
    nbits = 0;
  end

  always @(posedge ctrl_cclk) begin
    if (!ctrl_csn) begin
      sh = {sh[14:0], ctrl_cdata};
      nbits++;
    end
  end

  // only whole write frames count, a torn frame is dropped
  always @(posedge ctrl_csn) begin
    if (nbits == 16 && sh[15] && power_down_pin_n) begin
      regs[sh[11:8]] = sh[7:0];
      log_q.push_back({mck_run, sh[14:0]});
    end
  end

  // gain is left alone across adc power down
  assign alc_active = regs[DEV_LIM][LIM_ALC_EN] & (regs[DEV_PWR][PWR_ADC_LEFT] | regs[DEV_PWR][PWR_ADC_RIGHT]);

  // one pclk stands for one sample period
  always @(posedge pclk) begin
    if (regs[DEV_PWR][PWR_ADC_LEFT] | regs[DEV_PWR][PWR_ADC_RIGHT]) begin
      init_cnt <= (init_cnt < INIT_SAMPLES) ? init_cnt + 1 : init_cnt;
    end else begin
      init_cnt <= 0;
    end
    if (mck_run) begin
      dev_bclk <= ~dev_bclk;
    end
  end
  assign data_valid = (init_cnt >= INIT_SAMPLES);
endmodule

/* File: rpcs_host_tb.sv */
// Purpose: self-checking bench for the record power and clock sequencing host
// Assumes: apb master in the bench, device model on the serial port
// Notes:   short wait parameters keep each sequence under a thousand cycles
`timescale 1ns/1ns
module rpcs_host_tb
  import rpcs_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready, pslverr, power_down_pin_n, ctrl_csn, ctrl_cclk, ctrl_cdata;
  logic [31:0] prdata;
  logic        mck_run, bclk_run, frame_run, alc_active, data_valid, dev_bclk;
  int          bad_count = 0;
  int          n_compared = 0;
  logic [31:0] r;
  logic        e;
  localparam logic [14:0] ST [0:8] = '{{DEV_FS, 8'h25}, {DEV_MIC_A, 8'h34}, {DEV_MIC_B, 8'h12},
    {DEV_TMR, 8'h02}, {DEV_REF, 8'hE1}, {DEV_LIM, 8'hC1}, {DEV_PWR, 8'h0C}, {DEV_CLK, 8'h07}, {DEV_PWR, 8'h0F}};
  localparam int NCLK [0:4] = '{2, 1, 2, 0, 0};
  localparam logic [2:0] RUN [0:4] = '{3'b100, 3'b011, 3'b111, 3'b111, 3'b100};

  always #10 pclk = ~pclk;

  rpcs_host #(.T_VCM_PLL(10), .T_PLL_ADC(20), .T_LOCK(30)) rpcs_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .power_down_pin_n(power_down_pin_n), .ctrl_csn(ctrl_csn), .ctrl_cclk(ctrl_cclk),
    .ctrl_cdata(ctrl_cdata), .mck_run(mck_run), .bclk_run(bclk_run), .frame_run(frame_run));

  rpcs_dev_model rpcs_dev_model_i (
    .pclk(pclk), .power_down_pin_n(power_down_pin_n), .ctrl_csn(ctrl_csn), .ctrl_cclk(ctrl_cclk),
    .ctrl_cdata(ctrl_cdata), .mck_run(mck_run), .alc_active(alc_active), .data_valid(data_valid),
    .dev_bclk(dev_bclk));

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held from setup until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 3000);
    chk(r[0], 1'b0);
  endtask

  function automatic logic [31:0] entry(input int i);
    return {16'h0, rpcs_dev_model_i.log_q[i]};
  endfunction

  task automatic t_reset();
    wait_idle();
    chk(r[1], 1'b1);
    apb(1'b0, REG_MODE, 32'h0);
    chk(r[2:0], MODE_RST);
    chk({mck_run, bclk_run, frame_run}, 3'b000);
    apb(1'b1, 8'h18, 32'h5);
    chk(e, 1'b1);
    apb(1'b0, 8'h1C, 32'h0);
    chk(e, 1'b1);
    $display("test reset and unmapped done");
  endtask

  task automatic t_record(input logic [2:0] m);
    int n0;
    apb(1'b1, REG_MODE, {29'h0, m});
    apb(1'b1, REG_FS, 32'h25);
    apb(1'b1, REG_MIC, 32'h1234);
    apb(1'b1, REG_ALC, 32'h0041_E102);
    n0 = rpcs_dev_model_i.log_q.size();
    apb(1'b1, REG_CMD, 32'h1 << CMD_START);
    wait_idle();
    chk(r[2], 1'b1);
    chk(alc_active, 1'b1);
    chk({mck_run, bclk_run, frame_run}, RUN[m]);
    if (m == 3'd0) begin
      chk(data_valid, 1'b0);
      repeat (3100) @(posedge pclk);
      chk(data_valid, 1'b1);
      chk(rpcs_dev_model_i.log_q.size() - n0, 9);
      for (int i = 0; i < 9; i++) begin
        chk(entry(n0 + i) & 32'h7FFF, ST[i]);
      end
    end
    apb(1'b1, REG_MODE, {29'h0, m ^ 3'd1});
    apb(1'b0, REG_MODE, 32'h0);
    chk(r[2:0], m);
    apb(1'b1, REG_CMD, 32'h1 << CMD_STOP);
    wait_idle();
    n0 = rpcs_dev_model_i.log_q.size();
    chk(entry(n0 - 2) & 32'h7FFF, {DEV_PWR, 8'h04});
    chk(entry(n0 - 1) & 32'h7FFF, {DEV_LIM, 8'h41});
    chk(alc_active, 1'b0);
    apb(1'b1, REG_CMD, 32'h1 << CMD_CLK_STOP);
    wait_idle();
    chk(rpcs_dev_model_i.log_q.size() - n0, NCLK[m]);
    for (int i = n0; i < rpcs_dev_model_i.log_q.size(); i++) begin
      chk(entry(i) & 32'hFF01, {m != 3'd1, DEV_CLK, 8'h00});
    end
    if (m == 3'd0 || m == 3'd2) begin
      chk(entry(n0 + 1) & 32'h7FFF, {DEV_CLK, 8'h00});
    end
    chk({mck_run, bclk_run, frame_run}, 3'b000);
    e = dev_bclk;
    repeat (4) @(posedge pclk);
    chk(dev_bclk, e);
    apb(1'b1, REG_CMD, 32'h1 << CMD_PWR_OFF);
    wait_idle();
    chk(entry(rpcs_dev_model_i.log_q.size() - 1), {1'b0, DEV_PWR, 8'h00});
    $display("test record mode %0d done", m);
  endtask

  // reset command after a start must clear the device and pulse the pin
  task automatic t_reset_cmd();
    int lowc;
    lowc = 0;
    apb(1'b1, REG_MODE, 32'h0);
    apb(1'b1, REG_CMD, 32'h1 << CMD_START);
    wait_idle();
    apb(1'b1, REG_CMD, 32'h1 << CMD_RESET);
    for (int i = 0; i < 30; i++) begin
      @(posedge pclk);
      if (power_down_pin_n === 1'b0) begin
        lowc++;
      end
      if (i == 3) begin
        chk(rpcs_dev_model_i.regs[DEV_PWR], 8'h00);
      end
    end
    chk(lowc >= RST_LOW_CYC, 1'b1);
    wait_idle();
    chk(r[2:1], 2'b01);
    $display("test reset command done");
  endtask

  initial begin
    #600000;
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    for (int m = 0; m < 5; m++) begin
      t_record(m[2:0]);
    end
    t_reset_cmd();
    print_verdict();
  end
endmodule
